// *** rtl/ctps_params.svh ***
/*
 * constants for the capture timer with postscaler: addresses, fields,
 * reset values, prescale and time-format limits.
 * assumes inclusion by the timer module and the bench, not by ctps_pkg.sv.
 */
`ifndef CTPS_PARAMS_SVH
`define CTPS_PARAMS_SVH
`define CTPS_A_LOAD 32'hFFFF0320
`define CTPS_A_VAL 32'hFFFF0324
`define CTPS_A_CTRL 32'hFFFF0328
`define CTPS_A_CLR 32'hFFFF032C
`define CTPS_A_CAP 32'hFFFF0330
`define CTPS_RST_LOAD 32'h00000000
`define CTPS_RST_VAL 32'h0FFFFFFF
`define CTPS_RST_CTRL 32'h01000000
`define CTPS_RST_CAP 32'h00000000
`define CTPS_RST_POST 8'h01
`define CTPS_ZERO32 32'h00000000
`define CTPS_FULL32 32'hFFFFFFFF
`define CTPS_FMT_BIN 2'h0
`define CTPS_FMT_T23 2'h2
`define CTPS_FMT_T255 2'h3
`define CTPS_HMAX23 8'h17
`define CTPS_HMAX255 8'hFF
`define CTPS_MS_MAX 8'h3B
`define CTPS_HUND_MAX 8'h63
`define CTPS_PS_D1 4'h0
`define CTPS_PS_D16 4'h4
`define CTPS_PS_D256 4'h8
`define CTPS_PS_D32K 4'hF
`define CTPS_PM_D1 15'h0000
`define CTPS_PM_D16 15'h000F
`define CTPS_PM_D256 15'h00FF
`define CTPS_PM_D32K 15'h7FFF
`define CTPS_SRC_LP 2'h0
`define CTPS_SRC_DIV 2'h1
`define CTPS_SRC_REF 2'h2
`define CTPS_SRC_PIN 2'h3
`define CTPS_NSRC 18
`endif

// *** rtl/ctps_pkg.sv ***
/*
 * types for the capture timer with postscaler.
 * needs no include file; ctps_params.svh is not used here.
 */
package ctps_pkg;
    typedef struct packed {
        logic [7:0] post_tgt;
        logic post_en;
        logic [2:0] rsvd;
        logic post_flag;
        logic irq_src_post;
        logic cap_en;
        logic [4:0] cap_sel;
        logic rsvd11;
        logic [1:0] clk_sel;
        logic dir_up;
        logic run;
        logic periodic;
        logic [1:0] fmt;
        logic [3:0] presc;
    } ctps_ctrl_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } ctps_aph_t;
endpackage

// *** rtl/ctps_timer.sv ***
/*
 * capture timer with postscaler: AHB-Lite slave, clock source select,
 * prescaler, binary or time-format up/down counter, postscaler,
 * event capture and timer interrupt request.
 * assumes one clock MCLK_I; source pins are asynchronous and are
 * synchronised here; interrupt lines and enables come from MCLK_I logic.
 */
// Behaviour
// [RULE1] free-run restarts at max or min
// [RULE2] periodic restarts from reload value
// [RULE3] overflow reloads counter from reload value
// [RULE4] interrupt on each zero or full scale
// [RULE5] any write to clear drops interrupt
// [RULE6] count readable anytime, counting undisturbed
// [RULE7] bit 7 runs timer, default stopped
// [RULE8] bit 8 selects up, default down
// [RULE9] bit 6 selects periodic, default free-run
// [RULE10] bits 10:9 choose counting clock source
// [RULE11] prescale source by 1,16,256,32768
// [RULE12] binary or hours:minutes:seconds:hundredths count
// [RULE13] first selected source assertion captures count
// [RULE14] capture only from enabled interrupt sources
// [RULE15] bit 17 capture enable, bits 16:12 select
// [RULE16] event numbers map to peripheral sources
// [RULE17] postscaler target 1-256, reads current count; code takes 1-255, a write of 0 sets 1
// [RULE18] bit 23 enables postscaler timeout counting
// [RULE19] bit 18 picks postscaler interrupt source
// [RULE20] bit 19 flags postscaler match
// [RULE21] lp or pin source counts in sleep
// [RULE22] software loads reload before control, zeros
// [RULE23] prescale codes 0000,0100,1000,1111
// [RULE24] format codes binary, 23h, 255h
// [RULE25] interrupt sticky, set beats clear
// [RULE26] postscaler count restarts at target
`timescale 1ns/10ps
`include "ctps_params.svh"
module ctps_timer
    import ctps_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic LP_OSC_I,
    input wire logic REF_CLK_I,
    input wire logic EXTERNAL_COUNT_PIN_I,
    input wire logic [2:0] CORE_CLOCK_DIVIDER_I,
    input wire logic CORE_SLEEP_I,
    input wire logic [`CTPS_NSRC-1:0] IRQ_LINES_I,
    input wire logic [`CTPS_NSRC-1:0] IRQ_ENABLE_I,
    output logic TMR_IRQ_O
);
    function automatic logic [14:0] presc_max(input logic [3:0] code);
        case (code)
            `CTPS_PS_D16: presc_max = `CTPS_PM_D16;
            `CTPS_PS_D256: presc_max = `CTPS_PM_D256;
            `CTPS_PS_D32K: presc_max = `CTPS_PM_D32K;
            default: presc_max = `CTPS_PM_D1;
        endcase
    endfunction
    function automatic logic [7:0] hour_max(input logic [1:0] fmt);
        hour_max = (fmt == `CTPS_FMT_T23) ? `CTPS_HMAX23 : `CTPS_HMAX255;
    endfunction
    function automatic logic is_time(input logic [1:0] fmt);
        is_time = (fmt == `CTPS_FMT_T23) || (fmt == `CTPS_FMT_T255);
    endfunction
    function automatic logic [31:0] full_scale(input logic [1:0] fmt);
        if (is_time(fmt)) begin
            full_scale = {hour_max(fmt), `CTPS_MS_MAX, `CTPS_MS_MAX, `CTPS_HUND_MAX};
        end else begin
            full_scale = `CTPS_FULL32;
        end
    endfunction
    // one step of the time-format count, with carry or borrow
    function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up, input logic [7:0] hmax);
        logic [31:0] r;
        logic carry;
        logic [7:0] lim;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++) begin
            lim = (i == 0) ? `CTPS_HUND_MAX : ((i == 3) ? hmax : `CTPS_MS_MAX);
            if (carry) begin
                if (up) begin
                    if (r[i*8+:8] >= lim) begin
                        r[i*8+:8] = 8'h00;
                    end else begin
                        r[i*8+:8] = r[i*8+:8] + 8'h01;
                        carry = 1'b0;
                    end
                end else begin
                    if (r[i*8+:8] == 8'h00) begin
                        r[i*8+:8] = lim;
                    end else begin
                        r[i*8+:8] = r[i*8+:8] - 8'h01;
                        carry = 1'b0;
                    end
                end
            end
        end
        tm_step = r;
    endfunction

    ctps_ctrl_t ctrl_r;
    ctps_aph_t aph_r;
    logic [31:0] load_r;
    logic [31:0] cnt_r;
    logic [31:0] cap_r;
    logic [7:0] post_cnt_r;
    logic irq_r;
    logic [31:0] hrdata_r;
    logic [2:0] lp_s_r;
    logic [2:0] ref_s_r;
    logic [2:0] pin_s_r;
    logic [6:0] div_cnt_r;
    logic [14:0] pre_cnt_r;
    logic cnt_tick_r;
    logic evt_prev_r;
    logic aph_take;
    logic wr_load;
    logic wr_ctrl;
    logic wr_clr;
    logic [6:0] div_mask;
    logic lp_edge;
    logic ref_edge;
    logic pin_edge;
    logic div_edge;
    logic src_tick;
    logic at_end;
    logic timeout;
    logic post_hit;
    logic irq_evt;
    logic evt_now;
    logic cap_evt;
    logic [31:0] restart_val;
    logic [31:0] cnt_nxt;
    logic [31:0] rd_nxt;
    logic [7:0] post_tgt_wr;
    ctps_ctrl_t ctrl_wr;
    // bus address phase and decode
    assign aph_take = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wr_load = aph_r.valid && aph_r.write && (aph_r.addr == `CTPS_A_LOAD);
    assign wr_ctrl = aph_r.valid && aph_r.write && (aph_r.addr == `CTPS_A_CTRL);
    assign wr_clr = aph_r.valid && aph_r.write && (aph_r.addr == `CTPS_A_CLR);

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aph_r <= '0;
        end else begin
            aph_r.valid <= aph_take;
            aph_r.write <= HWRITE_I;
            aph_r.addr <= HADDR_I;
        end
    end

    always_comb begin
        rd_nxt = `CTPS_ZERO32;
        case (HADDR_I)
            `CTPS_A_LOAD: rd_nxt = load_r;
            `CTPS_A_VAL: rd_nxt = cnt_r; // [RULE6]
            `CTPS_A_CTRL: rd_nxt = {post_cnt_r, ctrl_r[23:0]}; // [RULE17]
            `CTPS_A_CAP: rd_nxt = cap_r;
            default: rd_nxt = `CTPS_ZERO32;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            hrdata_r <= `CTPS_ZERO32;
            HREADYOUT_O <= 1'b0;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            if (aph_take && !HWRITE_I) begin
                hrdata_r <= rd_nxt;
            end
        end
    end
    assign HRDATA_O = hrdata_r;
    // control and reload registers
    assign ctrl_wr = HWDATA_I;
    assign post_tgt_wr = (ctrl_wr.post_tgt == 8'h00) ? 8'h01 : ctrl_wr.post_tgt; // [RULE17]
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            load_r <= `CTPS_RST_LOAD;
        end else if (wr_load) begin
            load_r <= HWDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_r <= `CTPS_RST_CTRL;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= HWDATA_I; // [RULE7] [RULE8] [RULE9] [RULE15] [RULE18] [RULE19]
                ctrl_r.post_tgt <= post_tgt_wr;
                ctrl_r.rsvd <= 3'h0; // [RULE22]
                ctrl_r.rsvd11 <= 1'b0;
                ctrl_r.post_flag <= post_hit;
            end else if (post_hit) begin
                ctrl_r.post_flag <= 1'b1; // [RULE20]
            end
        end
    end
    // source synchronisers and edges
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lp_s_r <= 3'h0;
            ref_s_r <= 3'h0;
            pin_s_r <= 3'h0;
        end else begin
            lp_s_r <= {lp_s_r[1:0], LP_OSC_I};
            ref_s_r <= {ref_s_r[1:0], REF_CLK_I};
            pin_s_r <= {pin_s_r[1:0], EXTERNAL_COUNT_PIN_I};
        end
    end
    assign lp_edge = lp_s_r[1] && !lp_s_r[2];
    assign ref_edge = ref_s_r[1] && !ref_s_r[2];
    assign pin_edge = pin_s_r[1] && !pin_s_r[2];
    // reference divided by two to the core clock divider
    assign div_mask = 7'((8'h01 << CORE_CLOCK_DIVIDER_I) - 8'h01);
    assign div_edge = ref_edge && ((div_cnt_r & div_mask) == div_mask);

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_cnt_r <= 7'h00;
        end else if (ref_edge) begin
            div_cnt_r <= div_cnt_r + 7'h01;
        end
    end

    always_comb begin
        case (ctrl_r.clk_sel) // [RULE10]
            `CTPS_SRC_LP: src_tick = lp_edge; // [RULE21]
            `CTPS_SRC_DIV: src_tick = div_edge && !CORE_SLEEP_I;
            `CTPS_SRC_REF: src_tick = ref_edge && !CORE_SLEEP_I;
            `CTPS_SRC_PIN: src_tick = pin_edge; // [RULE21]
            default: src_tick = 1'b0;
        endcase
    end
    // prescaler
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pre_cnt_r <= 15'h0000;
            cnt_tick_r <= 1'b0;
        end else begin
            cnt_tick_r <= 1'b0;
            if (wr_ctrl) begin
                pre_cnt_r <= 15'h0000;
            end else if (src_tick && ctrl_r.run) begin
                if (pre_cnt_r >= presc_max(ctrl_r.presc)) begin // [RULE11] [RULE23]
                    pre_cnt_r <= 15'h0000;
                    cnt_tick_r <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 15'h0001;
                end
            end
        end
    end
    // counter
    assign at_end = ctrl_r.dir_up ? (cnt_r == full_scale(ctrl_r.fmt)) : (cnt_r == `CTPS_ZERO32);
    assign timeout = cnt_tick_r && ctrl_r.run && !wr_ctrl && at_end;

    always_comb begin
        if (ctrl_r.periodic) begin
            restart_val = load_r; // [RULE2] [RULE3]
        end else if (ctrl_r.dir_up) begin
            restart_val = `CTPS_ZERO32; // [RULE1]
        end else begin
            restart_val = full_scale(ctrl_r.fmt); // [RULE1]
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (timeout) begin
            cnt_nxt = restart_val;
        end else if (is_time(ctrl_r.fmt)) begin
            cnt_nxt = tm_step(cnt_r, ctrl_r.dir_up, hour_max(ctrl_r.fmt)); // [RULE12] [RULE24]
        end else if (ctrl_r.dir_up) begin
            cnt_nxt = cnt_r + 32'h00000001;
        end else begin
            cnt_nxt = cnt_r - 32'h00000001;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cnt_r <= `CTPS_RST_VAL;
        end else if (wr_ctrl && ctrl_wr.run && !ctrl_r.run) begin
            cnt_r <= ctrl_wr.periodic ? load_r : (ctrl_wr.dir_up ? `CTPS_ZERO32 : full_scale(ctrl_wr.fmt)); // [RULE7]
        end else if (cnt_tick_r && ctrl_r.run && !wr_ctrl) begin
            cnt_r <= cnt_nxt; // [RULE8]
        end
    end
    // postscaler, counts down the timeouts still to go
    assign post_hit = timeout && ctrl_r.post_en && (post_cnt_r <= 8'h01);
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            post_cnt_r <= `CTPS_RST_POST;
        end else if (wr_ctrl) begin
            post_cnt_r <= post_tgt_wr;
        end else if (post_hit) begin
            post_cnt_r <= ctrl_r.post_tgt; // [RULE26]
        end else if (timeout && ctrl_r.post_en) begin
            post_cnt_r <= post_cnt_r - 8'h01; // [RULE18]
        end
    end
    // interrupt request
    assign irq_evt = ctrl_r.irq_src_post ? post_hit : timeout; // [RULE4] [RULE19]

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_r <= 1'b0;
        end else if (irq_evt) begin
            irq_r <= 1'b1; // [RULE25]
        end else if (wr_clr) begin
            irq_r <= 1'b0; // [RULE5]
        end
    end
    assign TMR_IRQ_O = irq_r;
    // event capture, selects past the last line see nothing
    assign evt_now = (ctrl_r.cap_sel < 5'(`CTPS_NSRC)) && // [RULE16]
        IRQ_LINES_I[ctrl_r.cap_sel] && IRQ_ENABLE_I[ctrl_r.cap_sel]; // [RULE14]
    assign cap_evt = ctrl_r.cap_en && evt_now && !evt_prev_r; // [RULE13] [RULE15]
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            evt_prev_r <= 1'b0;
            cap_r <= `CTPS_RST_CAP;
        end else begin
            evt_prev_r <= evt_now;
            if (cap_evt) begin
                cap_r <= cnt_r; // [RULE13]
            end
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    property p_irq_hold;
        irq_r && !wr_clr |=> irq_r;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear"); // [RULE25]
    property p_irq_clear;
        wr_clr && !irq_evt |=> !irq_r;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("clear write ignored"); // [RULE5]
    property p_irq_direct;
        timeout && !ctrl_r.irq_src_post |=> irq_r;
    endproperty
    a_irq_direct: assert property (p_irq_direct) else $error("timeout raised no irq"); // [RULE4]
    property p_free_down;
        timeout && !ctrl_r.periodic && !ctrl_r.dir_up |=> cnt_r == full_scale($past(ctrl_r.fmt));
    endproperty
    a_free_down: assert property (p_free_down) else $error("free-run did not restart at max"); // [RULE1]
    property p_periodic;
        timeout && ctrl_r.periodic |=> cnt_r == $past(load_r);
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic did not reload"); // [RULE2]
    property p_stopped;
        !ctrl_r.run && !wr_ctrl |=> $stable(cnt_r);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer moved"); // [RULE7]
    property p_up_bin;
        cnt_tick_r && ctrl_r.run && !wr_ctrl && ctrl_r.dir_up && ctrl_r.fmt == `CTPS_FMT_BIN && !at_end
            |=> cnt_r == $past(cnt_r) + 32'h00000001;
    endproperty
    a_up_bin: assert property (p_up_bin) else $error("up count wrong"); // [RULE8]
    property p_capture;
        cap_evt |=> cap_r == $past(cnt_r);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong"); // [RULE13]
    property p_cap_off;
        !ctrl_r.cap_en |=> $stable(cap_r);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture while disabled"); // [RULE15]
    property p_post_flag;
        post_hit && !wr_ctrl |=> ctrl_r.post_flag && post_cnt_r == $past(ctrl_r.post_tgt);
    endproperty
    a_post_flag: assert property (p_post_flag) else $error("postscaler match not flagged"); // [RULE20]
    c_timeout: cover property (timeout ##[1:50] wr_clr);
    c_capture: cover property (cap_evt);
    c_post: cover property (post_hit && ctrl_r.irq_src_post);
endmodule

// *** bench/test_ctps_timer.sv ***
/*
 * self-checking bench for the capture timer: AHB-Lite tasks, register
 * defaults, counting, interrupt, postscaler and capture tests.
 * assumes ctps_pkg compiled first and ctps_params.svh on the include path.
 */
`timescale 1ns/10ps
`include "ctps_params.svh"
module test_ctps_timer
    import ctps_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic ref_clk = 1'b0;
    logic lp_osc = 1'b0;
    logic pin = 1'b0;
    logic sleep = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [2:0] cdiv = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [17:0] lines = 18'h0;
    logic [17:0] irq_en = 18'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] rd;
    logic [31:0] v;
    logic [31:0] exp_cap;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] addr[6] = '{`CTPS_A_LOAD, `CTPS_A_VAL, `CTPS_A_CTRL, `CTPS_A_CLR, `CTPS_A_CAP, 32'hFFFF0334};
    logic [31:0] rstv[6] = '{`CTPS_RST_LOAD, `CTPS_RST_VAL, `CTPS_RST_CTRL, 32'h0, `CTPS_RST_CAP, 32'h0};
    logic [31:0] tc[9] = '{32'h680, 32'h684, 32'h688, 32'h780, 32'h7A0, 32'h480, 32'h280, 32'h080, 32'h6B0};
    int tp[9] = '{5, 32, 256, 3, 101, 0, 0, 4, 2};
    logic [31:0] te[9] = '{32'hFFFFFFFA, 32'hFFFFFFFD, 32'hFFFFFFFE, 32'h3, 32'h101, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'hFFFFFFFB, 32'hFF3B3B61};
    int sel[3] = '{1, 8, 17};

    always #4 mclk = ~mclk;
    always #48.3 ref_clk = ~ref_clk;

    ctps_timer u_dut (
        .MCLK_I(mclk),
        .RST_B_I(rst_b),
        .HSEL_I(hsel),
        .HADDR_I(haddr),
        .HTRANS_I(htrans),
        .HWRITE_I(hwrite),
        .HSIZE_I(hsize),
        .HWDATA_I(hwdata),
        .HREADY_I(hreadyout),
        .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout),
        .HRESP_O(hresp),
        .LP_OSC_I(lp_osc),
        .REF_CLK_I(ref_clk),
        .EXTERNAL_COUNT_PIN_I(pin),
        .CORE_CLOCK_DIVIDER_I(cdiv),
        .CORE_SLEEP_I(sleep),
        .IRQ_LINES_I(lines),
        .IRQ_ENABLE_I(irq_en),
        .TMR_IRQ_O(irq)
    );

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // one single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic pulse_pin(input int n);
        repeat (n) begin
            repeat (5) @(posedge mclk);
            pin <= 1'b1;
            lp_osc <= 1'b1;
            repeat (5) @(posedge mclk);
            pin <= 1'b0;
            lp_osc <= 1'b0;
        end
    endtask

    task automatic pulse_line(input int s);
        @(posedge mclk);
        lines[s] <= 1'b1;
        repeat (4) @(posedge mclk);
        lines[s] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic wait_irq(input int n);
        repeat (n) begin
            if (irq === 1'b1) break;
            @(posedge mclk);
        end
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, addr[i], 32'h0);
            chk("reset value", rstv[i], rd);
        end
        chk("response okay", 32'h0, {31'h0, hresp});
        bus(1'b1, `CTPS_A_LOAD, 32'hA5A55A5A);
        bus(1'b1, `CTPS_A_VAL, 32'h12345678);
        bus(1'b1, `CTPS_A_CAP, 32'h12345678);
        bus(1'b0, `CTPS_A_LOAD, 32'h0);
        chk("reload readback", 32'hA5A55A5A, rd);
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        chk("value read only", `CTPS_RST_VAL, rd);
        bus(1'b0, `CTPS_A_CAP, 32'h0);
        chk("capture read only", 32'h0, rd);
        $display("test registers done");

        // pin, lp and gated sources with core asleep
        sleep <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, `CTPS_A_CTRL, 32'h0);
            bus(1'b1, `CTPS_A_CTRL, tc[i]);
            pulse_pin(tp[i]);
            repeat (50) @(posedge mclk);
            bus(1'b0, `CTPS_A_VAL, 32'h0);
            chk("count after pulses", te[i], rd);
        end
        sleep <= 1'b0;
        $display("test sources done");

        bus(1'b1, `CTPS_A_CTRL, 32'h0);
        bus(1'b1, `CTPS_A_LOAD, 32'h3);
        bus(1'b1, `CTPS_A_CTRL, 32'h4C0);
        wait_irq(300);
        chk("irq periodic down", 32'h1, {31'h0, irq});
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        chk("count within reload", 32'h1, {31'h0, rd <= 32'h3});
        bus(1'b1, `CTPS_A_CTRL, 32'h480);
        repeat (80) @(posedge mclk);
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        chk("free-run wrap", 32'h1, {31'h0, rd > 32'hFFFFFF00});
        bus(1'b1, `CTPS_A_CTRL, 32'h400);
        repeat (30) @(posedge mclk);
        chk("irq sticky", 32'h1, {31'h0, irq});
        bus(1'b1, `CTPS_A_CLR, 32'h0);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test periodic down done");

        cdiv <= 3'h1;
        bus(1'b1, `CTPS_A_LOAD, 32'hFFFFFFFD);
        bus(1'b1, `CTPS_A_CTRL, 32'h3C0);
        wait_irq(300);
        chk("irq periodic up", 32'h1, {31'h0, irq});
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        chk("up count reloaded", 32'h1, {31'h0, rd >= 32'hFFFFFFFD});
        bus(1'b1, `CTPS_A_CTRL, 32'h300);
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        v = rd;
        repeat (30) @(posedge mclk);
        bus(1'b0, `CTPS_A_VAL, 32'h0);
        chk("stopped count", v, rd);
        bus(1'b1, `CTPS_A_CLR, 32'h0);
        $display("test periodic up done");

        bus(1'b1, `CTPS_A_CTRL, 32'h0);
        bus(1'b1, `CTPS_A_LOAD, 32'h1);
        bus(1'b1, `CTPS_A_CTRL, 32'h038404C0);
        repeat (40) @(posedge mclk);
        chk("irq held by postscaler", 32'h0, {31'h0, irq});
        wait_irq(100);
        chk("postscaled irq", 32'h1, {31'h0, irq});
        bus(1'b0, `CTPS_A_CTRL, 32'h0);
        chk("control flags", 32'h00880000, rd & 32'h00F80800);
        bus(1'b1, `CTPS_A_CTRL, 32'h400);
        bus(1'b1, `CTPS_A_CLR, 32'h0);
        $display("test postscaler done");

        sleep <= 1'b1;
        exp_cap = 32'h0;
        bus(1'b1, `CTPS_A_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `CTPS_A_CTRL, 32'h00020680 | (sel[i] << 12));
            pulse_pin(i + 1);
            repeat (10) @(posedge mclk);
            bus(1'b0, `CTPS_A_VAL, 32'h0);
            v = rd;
            irq_en <= 18'h0;
            pulse_line(sel[i]);
            bus(1'b0, `CTPS_A_CAP, 32'h0);
            chk("capture masked", exp_cap, rd);
            irq_en[sel[i]] <= 1'b1;
            pulse_line(sel[i]);
            bus(1'b0, `CTPS_A_CAP, 32'h0);
            chk("capture taken", v, rd);
            exp_cap = v;
        end
        $display("test capture done");
        report_and_stop;
    end
endmodule
